// *** pfsp_pkg.sv ***
`default_nettype none
package pfsp_pkg;
    // Pin timing at 20 MHz, 50 ns per cycle
    localparam int CLK_PERIOD_NS   = 50;
    localparam int ADDR_SETUP_NS   = 10;
    localparam int WRITE_PULSE_NS  = 90;
    localparam int PULSE_HIGH_NS   = 100;
    localparam int READ_ACCESS_NS  = 120;
    localparam int FLOAT_NS        = 30;
    localparam int TOGGLE_HIGH_NS  = 150;
    localparam int LOAD_WINDOW_US  = 150;
    localparam int PROG_CYCLE_MS   = 10;
    // Least times round up
    localparam int SETUP_CYC  = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WP_CYC     = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WPH_CYC    = (PULSE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACC_CYC    = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLOAT_CYC  = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OEHP_CYC   = (TOGGLE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Longest window rounds down
    localparam int LOAD_WINDOW_CYC = LOAD_WINDOW_US * 1000 / CLK_PERIOD_NS;
    localparam int PROG_CYCLE_CYC  = PROG_CYCLE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int SECTOR_BYTES    = 256;
    localparam int ADDR_W          = 19;
    localparam int CNT_W           = 18;
    localparam logic [7:0] FILL_BYTE = 8'hff;

    typedef struct packed {
        logic        chipSelN;
        logic        outEnN;
        logic        writeN;
        logic [18:0] addr;
        logic [7:0]  dataOut;
        logic        dataOe;
    } pfsp_pins_t;

    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_SETUP = 7'h02,
        ST_PULSE = 7'h04,
        ST_HIGH  = 7'h08,
        ST_READ  = 7'h10,
        ST_FLOAT = 7'h20,
        ST_POLL  = 7'h40
    } pfsp_state_t;
endpackage : pfsp_pkg
`default_nettype wire

// *** pfsp_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module pfsp_host #(
    parameter int LOAD_WINDOW = pfsp_pkg::LOAD_WINDOW_CYC,
    parameter int PROG_CYCLE  = pfsp_pkg::PROG_CYCLE_CYC
) (
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               reset_n,
    // Command port
    input  wire logic               cmdValid,
    output logic                    cmdReady,
    input  wire logic               cmdWrite,
    input  wire logic               cmdLast,
    input  wire logic [18:0]        cmdAddr,
    input  wire logic [7:0]         cmdData,
    output logic                    rspValid,
    output logic [7:0]              rspData,
    output logic                    progDone,
    output logic                    progTimeout,
    // Device pins
    output pfsp_pkg::pfsp_pins_t    pins,
    input  wire logic [7:0]         dataIn
);
    // Window must leave room for a pulse before the lapse margin
    if (LOAD_WINDOW <= 2 * pfsp_pkg::WP_CYC || LOAD_WINDOW >= (1 << pfsp_pkg::CNT_W))
        $error("LOAD_WINDOW out of range");
    if (PROG_CYCLE < 2 || PROG_CYCLE >= (1 << pfsp_pkg::CNT_W))
        $error("PROG_CYCLE out of range");

    ////////////////////////////////////////////////////////////////////////////
    // Pin input synchroniser, three stages
    logic [7:0] sync1_reg, sync2_reg, sync3_reg;
    logic [7:0] stable_reg, stable_next;
    always_comb
    begin
        stable_next = stable_reg;
        if (sync2_reg == sync3_reg)
            stable_next = sync3_reg;
    end
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            sync1_reg  <= 8'h00;
            sync2_reg  <= 8'h00;
            sync3_reg  <= 8'h00;
            stable_reg <= 8'h00;
        end
        else
        begin
            sync1_reg  <= dataIn;
            sync2_reg  <= sync1_reg;
            sync3_reg  <= sync2_reg;
            stable_reg <= stable_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    pfsp_pkg::pfsp_state_t state_reg, state_next;
    pfsp_pkg::pfsp_pins_t  pins_reg, pins_next;
    logic [pfsp_pkg::CNT_W-1:0] cnt_reg, cnt_next;
    logic [pfsp_pkg::CNT_W-1:0] win_reg, win_next;
    logic [8:0]  loaded_reg, loaded_next;
    logic        loading_reg, loading_next;
    logic        lastCmd_reg, lastCmd_next;
    logic [7:0]  lastData_reg, lastData_next;
    logic [7:0]  prevRead_reg, prevRead_next;
    logic [10:0] sector_reg, sector_next;
    logic        rspValid_reg, rspValid_next;
    logic [7:0]  rspData_reg, rspData_next;
    logic        done_reg, done_next, tmo_reg, tmo_next;

    always_comb
    begin
        state_next    = state_reg;
        pins_next     = pins_reg;
        cnt_next      = cnt_reg;
        win_next      = win_reg;
        loaded_next   = loaded_reg;
        loading_next  = loading_reg;
        lastCmd_next  = lastCmd_reg;
        lastData_next = lastData_reg;
        prevRead_next = prevRead_reg;
        sector_next   = sector_reg;
        rspValid_next = 1'b0;
        rspData_next  = rspData_reg;
        done_next     = 1'b0;
        tmo_next      = 1'b0;
        cmdReady      = 1'b0;
        // Window runs from each rising strobe edge
        if (loading_reg && state_reg != pfsp_pkg::ST_PULSE)
            win_next = win_reg + 1'b1;
        if (loading_reg && win_reg >= pfsp_pkg::CNT_W'(LOAD_WINDOW - 2 * pfsp_pkg::WP_CYC))
            tmo_next = 1'b1;
        unique case (state_reg)
            pfsp_pkg::ST_IDLE:
            begin
                // Window nearly gone: a late pulse could land after the lapse
                cmdReady = !tmo_next;
                if (!cmdReady)
                    state_next = pfsp_pkg::ST_POLL;
                else if (cmdValid)
                begin
                    pins_next.addr = cmdAddr;
                    cnt_next       = '0;
                    if (cmdWrite)
                    begin
                        pins_next.outEnN   = 1'b1;
                        pins_next.chipSelN = 1'b0;
                        pins_next.dataOut  = cmdData;
                        pins_next.dataOe   = 1'b1;
                        if (loading_reg)
                            pins_next.addr[18:8] = sector_reg;
                        else
                            sector_next = cmdAddr[18:8];
                        lastCmd_next  = cmdLast;
                        lastData_next = cmdData;
                        state_next    = pfsp_pkg::ST_SETUP;
                    end
                    else
                    begin
                        pins_next.chipSelN = 1'b0;
                        pins_next.outEnN   = 1'b0;
                        state_next         = pfsp_pkg::ST_READ;
                    end
                end
            end
            pfsp_pkg::ST_SETUP:
            begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg >= pfsp_pkg::CNT_W'(pfsp_pkg::SETUP_CYC - 1))
                begin
                    pins_next.writeN = 1'b0;
                    cnt_next         = '0;
                    state_next       = pfsp_pkg::ST_PULSE;
                end
            end
            pfsp_pkg::ST_PULSE:
            begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg >= pfsp_pkg::CNT_W'(pfsp_pkg::WP_CYC - 1))
                begin
                    pins_next.writeN = 1'b1;
                    cnt_next         = '0;
                    win_next         = '0;
                    loading_next     = 1'b1;
                    loaded_next      = loaded_reg + 1'b1;
                    state_next       = pfsp_pkg::ST_HIGH;
                end
            end
            pfsp_pkg::ST_HIGH:
            begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg >= pfsp_pkg::CNT_W'(pfsp_pkg::WPH_CYC - 1))
                begin
                    pins_next.dataOe   = 1'b0;
                    pins_next.chipSelN = 1'b1;
                    cnt_next           = '0;
                    // Last byte: stop loading, let the window lapse
                    if (lastCmd_reg || loaded_reg == 9'(pfsp_pkg::SECTOR_BYTES))
                        state_next = pfsp_pkg::ST_POLL;
                    else
                        state_next = pfsp_pkg::ST_IDLE;
                end
            end
            pfsp_pkg::ST_READ:
            begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg >= pfsp_pkg::CNT_W'(pfsp_pkg::ACC_CYC + 3))
                begin
                    // Wait covers access time and the input synchroniser
                    rspValid_next      = 1'b1;
                    rspData_next       = stable_reg;
                    pins_next.outEnN   = 1'b1;
                    pins_next.chipSelN = 1'b1;
                    cnt_next           = '0;
                    state_next         = pfsp_pkg::ST_FLOAT;
                end
            end
            pfsp_pkg::ST_FLOAT:
            begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg >= pfsp_pkg::CNT_W'(pfsp_pkg::OEHP_CYC + pfsp_pkg::FLOAT_CYC))
                begin
                    cnt_next   = '0;
                    state_next = pfsp_pkg::ST_IDLE;
                end
            end
            pfsp_pkg::ST_POLL:
            begin
                // Poll the last loaded byte after the window lapses
                cnt_next = cnt_reg + 1'b1;
                if (loading_reg && win_reg >= pfsp_pkg::CNT_W'(LOAD_WINDOW))
                begin
                    loading_next = 1'b0;
                    cnt_next     = '0;
                end
                else if (!loading_reg)
                begin
                    if (cnt_reg == pfsp_pkg::CNT_W'(pfsp_pkg::ACC_CYC + 3))
                    begin
                        pins_next.chipSelN = 1'b0;
                        pins_next.outEnN   = 1'b0;
                    end
                    else if (cnt_reg == pfsp_pkg::CNT_W'(2 * pfsp_pkg::ACC_CYC + 7))
                    begin
                        prevRead_next      = stable_reg;
                        pins_next.chipSelN = 1'b1;
                        pins_next.outEnN   = 1'b1;
                        cnt_next           = '0;
                        if (stable_reg[7] == lastData_reg[7]
                            && stable_reg[6] == prevRead_reg[6])
                        begin
                            done_next   = 1'b1;
                            loaded_next = '0;
                            state_next  = pfsp_pkg::ST_IDLE;
                        end
                    end
                    win_next = win_reg + 1'b1;
                    if (win_reg >= pfsp_pkg::CNT_W'(PROG_CYCLE))
                    begin
                        tmo_next           = 1'b1;
                        done_next          = 1'b1;
                        loaded_next        = '0;
                        pins_next.chipSelN = 1'b1;
                        pins_next.outEnN   = 1'b1;
                        state_next         = pfsp_pkg::ST_IDLE;
                    end
                end
                if (loading_reg && win_reg >= pfsp_pkg::CNT_W'(LOAD_WINDOW))
                    win_next = '0;
            end
            default:
                state_next = pfsp_pkg::ST_IDLE;
        endcase
        if (state_reg != pfsp_pkg::ST_POLL || loading_reg)
            tmo_next = tmo_next && state_reg == pfsp_pkg::ST_IDLE;
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            state_reg    <= pfsp_pkg::ST_IDLE;
            pins_reg     <= '{chipSelN: 1'b1, outEnN: 1'b1, writeN: 1'b1,
                              addr: 19'h00000, dataOut: 8'h00, dataOe: 1'b0};
            cnt_reg      <= '0;
            win_reg      <= '0;
            loaded_reg   <= 9'h000;
            loading_reg  <= 1'b0;
            lastCmd_reg  <= 1'b0;
            lastData_reg <= 8'h00;
            prevRead_reg <= 8'h00;
            sector_reg   <= 11'h000;
            rspValid_reg <= 1'b0;
            rspData_reg  <= 8'h00;
            done_reg     <= 1'b0;
            tmo_reg      <= 1'b0;
        end
        else
        begin
            state_reg    <= state_next;
            pins_reg     <= pins_next;
            cnt_reg      <= cnt_next;
            win_reg      <= win_next;
            loaded_reg   <= loaded_next;
            loading_reg  <= loading_next;
            lastCmd_reg  <= lastCmd_next;
            lastData_reg <= lastData_next;
            prevRead_reg <= prevRead_next;
            sector_reg   <= sector_next;
            rspValid_reg <= rspValid_next;
            rspData_reg  <= rspData_next;
            done_reg     <= done_next;
            tmo_reg      <= tmo_next;
        end
    end

    assign pins        = pins_reg;
    assign rspValid    = rspValid_reg;
    assign rspData     = rspData_reg;
    assign progDone    = done_reg;
    assign progTimeout = tmo_reg;
endmodule : pfsp_host
`default_nettype wire

// *** pfsp_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module pfsp_assertions #(
    parameter int LOAD_WINDOW = 3000,
    parameter int PROG_CYCLE  = 200000
) (
    // Clock and reset
    input wire logic                 core_clk,
    input wire logic                 reset_n,
    // Observed outputs
    input wire logic                 rspValid,
    input wire pfsp_pkg::pfsp_pins_t pins
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////////
    reset_idle_a: assert property ($rose(reset_n) |-> pins.chipSelN && pins.outEnN
        && pins.writeN && !pins.dataOe) else $error("pins not idle after reset");
    read_no_drive_a: assert property (!pins.outEnN |-> !pins.dataOe)
        else $error("host drives data during read");
    read_strobes_a: assert property (!pins.outEnN |-> !pins.chipSelN && pins.writeN)
        else $error("read strobes wrong");
    load_strobes_a: assert property (!pins.writeN |-> !pins.chipSelN && pins.outEnN
        && pins.dataOe) else $error("load pulse without select or with output on");
    pulse_width_a: assert property ($fell(pins.writeN) |-> !pins.writeN [*2])
        else $error("write pulse too short");
    pulse_high_a: assert property ($rose(pins.writeN) |-> pins.writeN [*2])
        else $error("write high time too short");
    load_addr_stable_a: assert property (!pins.writeN |-> $stable(pins.addr)
        && $stable(pins.dataOut)) else $error("address or data moved in pulse");
    resp_after_read_a: assert property (rspValid |-> $past(pins.outEnN) == 1'b0)
        else $error("response without read strobe");
endmodule : pfsp_assertions
`default_nettype wire

// *** pfsp_flash_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module pfsp_flash_model #(
    parameter int         LOAD_WINDOW = 40,
    parameter int         PROG_T      = 300,
    parameter logic [7:0] ID_ENTER    = 8'h90, // Arbitrary command values
    parameter logic [7:0] ID_EXIT     = 8'hf0,
    parameter logic [7:0] MFR_CODE    = 8'h9e, // Arbitrary identity values
    parameter logic [7:0] DEV_CODE    = 8'h2b
) (
    // Clock
    input wire logic                 core_clk,
    // Host pins
    input wire pfsp_pkg::pfsp_pins_t pins,
    output logic [7:0]               devData
);
    logic [7:0]  mem [0:(1 << pfsp_pkg::ADDR_W) - 1];
    logic [7:0]  pend [0:pfsp_pkg::SECTOR_BYTES - 1];
    logic [18:0] latAddr;
    logic [10:0] secAddr;
    logic [7:0]  lastData, rd;
    logic [7:0]  lastOut = 8'h00;
    logic        prevWe = 1'b1, prevOe = 1'b1, loading = 1'b0, busy = 1'b0;
    logic        idMode = 1'b0, tog = 1'b0;
    int          winCnt = 0, progCnt = 0;
    wire logic   drv = !pins.chipSelN && !pins.outEnN;

    initial
    begin
        // Erased array and empty load buffer
        foreach (mem[i]) mem[i] = pfsp_pkg::FILL_BYTE;
        foreach (pend[i]) pend[i] = pfsp_pkg::FILL_BYTE;
    end

    always_comb
    begin
        if (busy) rd = {~lastData[7], tog, lastData[5:0]};
        else if (idMode) rd = pins.addr[0] ? DEV_CODE : MFR_CODE;
        else rd = mem[pins.addr];
    end
    // Released lines must not look like held data
    assign devData = drv ? rd : ~lastOut;

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk)
    begin
        prevWe <= pins.writeN;
        prevOe <= pins.outEnN;
        if (drv) lastOut <= rd;
        if (busy && prevOe && !pins.outEnN) tog <= ~tog;
        if (prevWe && !pins.writeN) latAddr <= pins.addr;
        // Limitation: a command byte at address 0 cannot be stored
        if (!prevWe && pins.writeN && !pins.chipSelN && pins.outEnN && !busy)
        begin
            if (latAddr == '0 && pins.dataOut == ID_ENTER) idMode <= 1'b1;
            else if (latAddr == '0 && pins.dataOut == ID_EXIT) idMode <= 1'b0;
            else
            begin
                if (!loading) secAddr <= latAddr[18:8];
                pend[latAddr[7:0]] <= pins.dataOut;
                lastData <= pins.dataOut;
                loading <= 1'b1;
            end
            winCnt <= 0;
        end
        else if (loading && winCnt < LOAD_WINDOW) winCnt <= winCnt + 1;
        else if (loading)
        begin
            for (int i = 0; i < pfsp_pkg::SECTOR_BYTES; i++)
            begin
                mem[{secAddr, i[7:0]}] <= pend[i];
                pend[i] <= pfsp_pkg::FILL_BYTE;
            end
            loading <= 1'b0;
            busy <= 1'b1;
            progCnt <= 0;
        end
        if (busy) progCnt <= progCnt + 1;
        if (busy && progCnt == PROG_T) busy <= 1'b0;
    end
endmodule : pfsp_flash_model
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam int         WIN = 40;
    localparam int         DEVT = 300;
    localparam logic [7:0] ENTER = 8'h90;
    localparam logic [7:0] LEAVE = 8'hf0;
    localparam logic [7:0] MFR = 8'h9e; // Arbitrary identity values
    localparam logic [7:0] DEV = 8'h2b;
    logic                 core_clk = 1'b0, reset_n = 1'b0, cmdValid = 1'b0;
    logic                 cmdWrite = 1'b0, cmdLast = 1'b0;
    logic [18:0]          cmdAddr = '0;
    logic [7:0]           cmdData = '0;
    logic                 cmdReady, rspValid, progDone, progTimeout, warn;
    logic [7:0]           rspData, dataIn;
    pfsp_pkg::pfsp_pins_t pins;
    int                   bad_count = 0, num_checks = 0, cycles = 0, n;

    always #25 core_clk = ~core_clk;
    pfsp_host #(.LOAD_WINDOW(WIN), .PROG_CYCLE(2000)) dut_u (.core_clk(core_clk),
        .reset_n(reset_n), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdWrite(cmdWrite),
        .cmdLast(cmdLast), .cmdAddr(cmdAddr), .cmdData(cmdData), .rspValid(rspValid),
        .rspData(rspData), .progDone(progDone), .progTimeout(progTimeout), .pins(pins),
        .dataIn(dataIn));
    pfsp_flash_model #(.LOAD_WINDOW(WIN), .PROG_T(DEVT), .ID_ENTER(ENTER), .ID_EXIT(LEAVE),
        .MFR_CODE(MFR), .DEV_CODE(DEV)) flash_u (.core_clk(core_clk), .pins(pins),
        .devData(dataIn));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [18:0] seen, input logic [18:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic cmd(input logic wr, input logic last, input logic [18:0] a,
                       input logic [7:0] d);
        @(posedge core_clk) #5;
        {cmdValid, cmdWrite, cmdLast, cmdAddr, cmdData} = {1'b1, wr, last, a, d};
        while (cmdReady !== 1'b1) @(posedge core_clk) #5;
        @(posedge core_clk) #5;
        cmdValid = 1'b0;
    endtask : cmd

    task automatic rd(input logic [18:0] a, input logic [7:0] exp, input string what);
        cmd(1'b0, 1'b0, a, 8'h00);
        for (int i = 0; i < 40 && rspValid !== 1'b1; i++) @(posedge core_clk) #5;
        chk(what, {rspValid, rspData}, {1'b1, exp});
    endtask : rd

    task automatic wait_done;
        for (n = 0; n < 3000 && progDone !== 1'b1; n++) @(posedge core_clk) #5;
        chk("program done", {progDone, progTimeout}, 2'b10);
    endtask : wait_done

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_sector;
        cmd(1'b1, 1'b0, {11'h012, 8'h05}, 8'h3c);
        cmd(1'b1, 1'b1, {11'h012, 8'h06}, 8'hc3);
        repeat (WIN + DEVT / 2) @(posedge core_clk) #5;
        chk("ready in programming", cmdReady, 1'b0);
        wait_done();
        rd({11'h012, 8'h05}, 8'h3c, "sector byte 5");
        rd({11'h012, 8'h06}, 8'hc3, "sector byte 6");
        rd({11'h012, 8'h07}, 8'hff, "unloaded byte");
    endtask : t_sector

    task automatic t_lapse;
        warn = 1'b0;
        cmd(1'b1, 1'b0, {11'h034, 8'h10}, 8'h81);
        cmd(1'b1, 1'b0, {11'h034, 8'h11}, 8'h7e);
        repeat (WIN + DEVT + 60) @(posedge core_clk) #5 warn |= progTimeout;
        chk("lapse warning", warn, 1'b1);
        rd({11'h034, 8'h10}, 8'h81, "lapsed byte 0");
        rd({11'h034, 8'h11}, 8'h7e, "lapsed byte 1");
    endtask : t_lapse

    task automatic t_full;
        for (int i = 0; i < 256; i++)
            cmd(1'b1, i == 255, {(i == 128) ? 11'h2aa : 11'h055, i[7:0]}, i[7:0]);
        wait_done();
        rd({11'h055, 8'h00}, 8'h00, "first byte");
        rd({11'h055, 8'h80}, 8'h80, "moved sector byte");
        rd({11'h055, 8'hff}, 8'hff, "last byte");
        rd({11'h2aa, 8'h80}, 8'hff, "other sector");
    endtask : t_full

    task automatic t_ident;
        cmd(1'b1, 1'b1, 19'h00000, ENTER);
        wait_done();
        rd(19'h00000, MFR, "maker code");
        rd(19'h00001, DEV, "device code");
        cmd(1'b1, 1'b1, 19'h00000, LEAVE);
        wait_done();
        rd({11'h012, 8'h05}, 8'h3c, "normal read after exit");
    endtask : t_ident

    task automatic end_sim;
        $display("checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            bad_count++;
            end_sim();
        end
    end

    initial
    begin
        repeat (4) @(posedge core_clk);
        #5;
        chk("reset pins", {pins.chipSelN, pins.outEnN, pins.writeN, pins.dataOe}, 4'b1110);
        reset_n = 1'b1;
        t_sector();
        t_lapse();
        t_full();
        t_ident();
        end_sim();
    end
endmodule : testbench

bind pfsp_host pfsp_assertions #(.LOAD_WINDOW(LOAD_WINDOW), .PROG_CYCLE(PROG_CYCLE)) chk_u (
    .core_clk(core_clk), .reset_n(reset_n), .rspValid(rspValid), .pins(pins));
`default_nettype wire
